// >>> src/switch_address_vlan_lookup.sv
// Forwarding look-up engine with static MAC and VLAN tables behind a Wishbone slave.
// Assumes the dynamic table answers combinationally while DYN_QUERY is high.
//
// Functional notes
// - Destination look-up searches static and dynamic tables.
// - Source look-up uses only the dynamic table.
// - Static destination hit beats dynamic hit.
// - Static entries change only by management writes.
// - Eight static entries, read layout shifted upward.
// - Static write layout: group 59..56, flag 55.
// - Group-qualified or MAC-only static match per entry.
// - Override bit bypasses spanning-tree port disable.
// - Invalid static entries are ignored.
// - Port mask bit per port; all-ones excludes ingress.
// - VLAN table consulted only in VLAN mode.
// - Sixteen VLAN entries of 22 bits.
// - VLAN entries reset valid, all members, ID 1.
// - Untagged or null tag takes port default ID.
// - Unknown VLAN drops packet, no learning.
// - Miss floods VLAN members except ingress.
// - Source miss learns group and source pair.
// - Address-low write launches command; bit4 selects read.
// - Indirect data spans bits 68..0, nine registers.
`timescale 1ns/10ps
module switch_address_vlan_lookup (
  input  wire logic        REF_CLK,      // Core clock, 100 MHz.
  input  wire logic        RST,          // Async reset, high.
  input  wire logic [8:0]  WB_ADR_I,     // Byte address.
  input  wire logic [31:0] WB_DAT_I,     // Write data.
  input  wire logic [3:0]  WB_SEL_I,     // Byte enables.
  input  wire logic        WB_WE_I,      // Write cycle.
  input  wire logic        WB_CYC_I,     // Bus cycle.
  input  wire logic        WB_STB_I,     // Strobe.
  output logic      [31:0] WB_DAT_O,     // Read data.
  output logic             WB_ACK_O,     // Acknowledge.
  input  wire logic        LKP_REQ,      // Look-up request pulse.
  input  wire logic [47:0] LKP_DA,       // Destination address.
  input  wire logic [47:0] LKP_SA,       // Source address.
  input  wire logic        LKP_TAGGED,   // Packet carries a VLAN tag.
  input  wire logic [11:0] LKP_TAG_VID,  // VLAN ID from the tag.
  input  wire logic [2:0]  LKP_PORT,     // Ingress port, 0 is port 1.
  output logic             DYN_QUERY,    // Dynamic table query pulse.
  output logic      [3:0]  DYN_FG,       // Filter group key.
  output logic      [47:0] DYN_DA,       // Destination key.
  output logic      [47:0] DYN_SA,       // Source key.
  input  wire logic        DYN_DA_HIT,   // Dynamic destination hit.
  input  wire logic [4:0]  DYN_DA_PORTS, // Dynamic forwarding ports.
  input  wire logic        DYN_SA_HIT,   // Dynamic source hit.
  output logic             RES_VALID,    // Result pulse.
  output logic      [4:0]  RES_PORTS,    // Forwarding ports.
  output logic             RES_DROP,     // Packet dropped.
  output logic             RES_OVERRIDE, // Spanning-tree bypass.
  output logic             RES_LEARN,    // Learn source into dynamic table.
  output logic      [3:0]  RES_FG,       // Filter group used.
  output logic      [11:0] RES_VID       // VLAN ID assigned.
);

  // ****************************************************************
  // Management registers
  // ****************************************************************
  logic [7:0]                       ctrl5, next_ctrl5;
  logic [7:0]                       ind_ctrl, next_ind_ctrl;
  logic [7:0]                       ind_addr, next_ind_addr;
  logic [lookup_pkg::IND_W-1:0]     ind_data, next_ind_data;
  logic [lookup_pkg::VID_W-1:0]     port_vid      [lookup_pkg::NUM_PORTS];
  logic [lookup_pkg::VID_W-1:0]     next_port_vid [lookup_pkg::NUM_PORTS];
  logic                             rd_pend1, next_rd_pend1;
  logic                             rd_pend2, next_rd_pend2;
  logic [1:0]                       rd_tbl, next_rd_tbl;
  logic [3:0]                       cmd_idx, next_cmd_idx;
  logic [31:0]                      next_dat;
  logic                             next_ack;
  logic                             st_wr_en, vt_wr_en;
  logic [lookup_pkg::STATIC_W-1:0]  st_rd_data;
  logic [lookup_pkg::VLAN_W-1:0]    vt_rd_data;
  logic [6:0]                       idx;
  logic                             trig;
  logic [1:0]                       tbl;
  logic [3:0]                       n_byte;

  // Nine data registers: index 0x78 holds bits 7..0, index 0x70 bits 68..64.
  function automatic logic is_data_idx(input logic [6:0] i);
    return i >= lookup_pkg::IDX_IND_DATA_TOP && i <= lookup_pkg::IDX_IND_DATA_LOW;
  endfunction

  function automatic logic is_vid_idx(input logic [6:0] i);
    return i >= lookup_pkg::IDX_PORT_VID_BASE
        && i < lookup_pkg::IDX_PORT_VID_BASE + 7'(lookup_pkg::NUM_PORTS);
  endfunction

  always_comb begin
    idx           = WB_ADR_I[8:2];
    n_byte        = 4'(lookup_pkg::IDX_IND_DATA_LOW - idx);
    tbl           = ind_ctrl[lookup_pkg::CTRL_TBL_LSB +: 2];
    next_ctrl5    = ctrl5;
    next_ind_ctrl = ind_ctrl;
    next_ind_addr = ind_addr;
    next_ind_data = ind_data;
    next_port_vid = port_vid;
    next_rd_pend1 = 1'b0;
    next_rd_pend2 = rd_pend1;
    next_rd_tbl   = rd_tbl;
    next_cmd_idx  = cmd_idx;
    next_dat      = '0;
    trig          = 1'b0;
    // Holding ack while a table read is in flight keeps stale data unreadable.
    next_ack      = WB_CYC_I && WB_STB_I && !WB_ACK_O && !rd_pend1 && !rd_pend2;
    if (next_ack && !WB_WE_I) begin
      if (idx == lookup_pkg::IDX_GLOBAL_CTRL5) begin
        next_dat[7:0] = ctrl5;
      end else if (idx == lookup_pkg::IDX_IND_CTRL) begin
        next_dat[7:0] = ind_ctrl;
      end else if (idx == lookup_pkg::IDX_IND_ADDR) begin
        next_dat[7:0] = ind_addr;
      end else if (is_data_idx(idx)) begin
        next_dat[7:0] = ind_data[8*n_byte +: 8];
      end else if (is_vid_idx(idx)) begin
        next_dat[lookup_pkg::VID_W-1:0] = port_vid[3'(idx - lookup_pkg::IDX_PORT_VID_BASE)];
      end
    end
    if (next_ack && WB_WE_I && WB_SEL_I[0]) begin
      if (idx == lookup_pkg::IDX_GLOBAL_CTRL5) begin
        next_ctrl5 = WB_DAT_I[7:0];
      end else if (idx == lookup_pkg::IDX_IND_CTRL) begin
        next_ind_ctrl = WB_DAT_I[7:0];
      end else if (idx == lookup_pkg::IDX_IND_ADDR) begin
        next_ind_addr = WB_DAT_I[7:0];
        next_cmd_idx  = WB_DAT_I[3:0];
        trig          = 1'b1;
      end else if (is_data_idx(idx)) begin
        next_ind_data[8*n_byte +: 8] = WB_DAT_I[7:0];
      end else if (is_vid_idx(idx)) begin
        next_port_vid[3'(idx - lookup_pkg::IDX_PORT_VID_BASE)][7:0] = WB_DAT_I[7:0];
      end
    end
    if (next_ack && WB_WE_I && WB_SEL_I[1] && is_vid_idx(idx)) begin
      next_port_vid[3'(idx - lookup_pkg::IDX_PORT_VID_BASE)][11:8] = WB_DAT_I[11:8];
    end
    next_ind_data[lookup_pkg::IND_W-1:lookup_pkg::IND_USED_W] = '0;
    st_wr_en = trig && !ind_ctrl[lookup_pkg::CTRL_READ_BIT] && tbl == lookup_pkg::TBL_STATIC;
    vt_wr_en = trig && !ind_ctrl[lookup_pkg::CTRL_READ_BIT] && tbl == lookup_pkg::TBL_VLAN;
    if (trig && ind_ctrl[lookup_pkg::CTRL_READ_BIT]
        && (tbl == lookup_pkg::TBL_STATIC || tbl == lookup_pkg::TBL_VLAN)) begin
      next_rd_pend1 = 1'b1;
      next_rd_tbl   = tbl;
    end
    if (rd_pend2) begin
      next_ind_data = '0;
      if (rd_tbl == lookup_pkg::TBL_STATIC) begin
        // The read layout inserts a reserved zero at bit 55.
        next_ind_data[60:0] = {st_rd_data[59:55], 1'b0, st_rd_data[54:0]};
      end else begin
        next_ind_data[lookup_pkg::VLAN_W-1:0] = vt_rd_data;
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ctrl5    <= lookup_pkg::REG_RESET;
      ind_ctrl <= lookup_pkg::REG_RESET;
      ind_addr <= lookup_pkg::REG_RESET;
      ind_data <= '0;
      for (int i = 0; i < lookup_pkg::NUM_PORTS; i++) begin
        port_vid[i] <= lookup_pkg::PORT_VID_RESET;
      end
      rd_pend1 <= 1'b0;
      rd_pend2 <= 1'b0;
      rd_tbl   <= lookup_pkg::TBL_STATIC;
      cmd_idx  <= '0;
      WB_DAT_O <= '0;
      WB_ACK_O <= 1'b0;
    end else begin
      ctrl5    <= next_ctrl5;
      ind_ctrl <= next_ind_ctrl;
      ind_addr <= next_ind_addr;
      ind_data <= next_ind_data;
      port_vid <= next_port_vid;
      rd_pend1 <= next_rd_pend1;
      rd_pend2 <= next_rd_pend2;
      rd_tbl   <= next_rd_tbl;
      cmd_idx  <= next_cmd_idx;
      WB_DAT_O <= next_dat;
      WB_ACK_O <= next_ack;
    end
  end

  // ****************************************************************
  // Look-up pipeline
  // ****************************************************************
  logic                             s1_v, s2_v, s3_v;
  logic                             next_s1_v, next_s2_v, next_s3_v;
  logic [47:0]                      s1_da, s1_sa, s2_da, s2_sa;
  logic [47:0]                      next_s1_da, next_s1_sa, next_s2_da, next_s2_sa;
  logic [2:0]                       s1_port, s2_port, s3_port;
  logic [2:0]                       next_s1_port, next_s2_port, next_s3_port;
  logic [11:0]                      s1_vid, s2_vid, s3_vid;
  logic [11:0]                      next_s1_vid, next_s2_vid, next_s3_vid;
  logic                             s1_mode, s2_mode;
  logic                             next_s1_mode, next_s2_mode;
  logic                             s3_drop, next_s3_drop;
  logic [4:0]                       s3_memb, next_s3_memb;
  logic [3:0]                       s2_fg, next_dyn_fg;
  logic                             s2_vlan_ok;
  logic                             vt_hit, st_hit, st_override;
  logic [4:0]                       vt_memb, st_ports;
  logic [3:0]                       vt_fg;
  logic                             next_dyn_query;
  logic [47:0]                      next_dyn_da, next_dyn_sa;
  logic                             next_res_valid, next_res_drop, next_res_override;
  logic                             next_res_learn;
  logic [4:0]                       next_res_ports, ingress;
  logic [3:0]                       next_res_fg;
  logic [11:0]                      next_res_vid;

  // An all-ones mask floods every port but the one the packet came in on.
  function automatic logic [4:0] expand_mask(input logic [4:0] m, input logic [4:0] ing);
    return (m == lookup_pkg::ALL_PORTS) ? (lookup_pkg::ALL_PORTS & ~ing) : m;
  endfunction

  always_comb begin
    next_s1_v    = LKP_REQ;
    next_s1_da   = LKP_DA;
    next_s1_sa   = LKP_SA;
    next_s1_port = LKP_PORT;
    next_s1_mode = ctrl5[lookup_pkg::VLAN_MODE_BIT];
    if (LKP_TAGGED && LKP_TAG_VID != '0) begin
      next_s1_vid = LKP_TAG_VID;
    end else if (LKP_PORT < 3'(lookup_pkg::NUM_PORTS)) begin
      next_s1_vid = port_vid[LKP_PORT];
    end else begin
      next_s1_vid = '0;
    end
    next_s2_v    = s1_v;
    next_s2_da   = s1_da;
    next_s2_sa   = s1_sa;
    next_s2_port = s1_port;
    next_s2_vid  = s1_vid;
    next_s2_mode = s1_mode;
    // Outside VLAN mode every packet belongs to one flat domain with group zero.
    s2_vlan_ok   = !s2_mode || vt_hit;
    s2_fg        = s2_mode ? vt_fg : '0;
    next_s3_v    = s2_v;
    next_s3_port = s2_port;
    next_s3_vid  = s2_vid;
    next_s3_drop = !s2_vlan_ok;
    next_s3_memb = s2_mode ? vt_memb : lookup_pkg::ALL_PORTS;
    next_dyn_query = s2_v;
    next_dyn_fg    = s2_fg;
    next_dyn_da    = s2_da;
    next_dyn_sa    = s2_sa;
    ingress        = 5'(5'h01 << s3_port);
    next_res_valid    = s3_v;
    next_res_drop     = s3_drop;
    next_res_fg       = DYN_FG;
    next_res_vid      = s3_vid;
    next_res_override = 1'b0;
    next_res_ports    = '0;
    next_res_learn    = 1'b0;
    if (s3_v && !s3_drop) begin
      if (st_hit) begin
        next_res_ports    = expand_mask(st_ports, ingress);
        next_res_override = st_override;
      end else if (DYN_DA_HIT) begin
        next_res_ports = expand_mask(DYN_DA_PORTS, ingress);
      end else begin
        next_res_ports = s3_memb & ~ingress;
      end
      next_res_learn = !DYN_SA_HIT;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      s1_v <= 1'b0; s2_v <= 1'b0; s3_v <= 1'b0;
      s1_da <= '0; s1_sa <= '0; s2_da <= '0; s2_sa <= '0;
      s1_port <= '0; s2_port <= '0; s3_port <= '0;
      s1_vid <= '0; s2_vid <= '0; s3_vid <= '0;
      s1_mode <= 1'b0; s2_mode <= 1'b0;
      s3_drop <= 1'b0; s3_memb <= '0;
      DYN_QUERY <= 1'b0; DYN_FG <= '0; DYN_DA <= '0; DYN_SA <= '0;
      RES_VALID <= 1'b0; RES_PORTS <= '0; RES_DROP <= 1'b0; RES_OVERRIDE <= 1'b0;
      RES_LEARN <= 1'b0; RES_FG <= '0; RES_VID <= '0;
    end else begin
      s1_v <= next_s1_v; s2_v <= next_s2_v; s3_v <= next_s3_v;
      s1_da <= next_s1_da; s1_sa <= next_s1_sa; s2_da <= next_s2_da; s2_sa <= next_s2_sa;
      s1_port <= next_s1_port; s2_port <= next_s2_port; s3_port <= next_s3_port;
      s1_vid <= next_s1_vid; s2_vid <= next_s2_vid; s3_vid <= next_s3_vid;
      s1_mode <= next_s1_mode; s2_mode <= next_s2_mode;
      s3_drop <= next_s3_drop; s3_memb <= next_s3_memb;
      DYN_QUERY <= next_dyn_query; DYN_FG <= next_dyn_fg;
      DYN_DA <= next_dyn_da; DYN_SA <= next_dyn_sa;
      RES_VALID <= next_res_valid; RES_PORTS <= next_res_ports; RES_DROP <= next_res_drop;
      RES_OVERRIDE <= next_res_override; RES_LEARN <= next_res_learn;
      RES_FG <= next_res_fg; RES_VID <= next_res_vid;
    end
  end

  // ****************************************************************
  // Tables
  // ****************************************************************
  static_mac_table #(.DEPTH(lookup_pkg::STATIC_DEPTH)) u_static (
    .clk      (REF_CLK),
    .rst      (RST),
    .wr_en    (st_wr_en),
    // The write lands on the trigger edge, so it must use the index being written.
    .wr_addr  (next_cmd_idx[2:0]),
    .wr_data  (ind_data[lookup_pkg::STATIC_W-1:0]),
    .rd_addr  (cmd_idx[2:0]),
    .rd_data  (st_rd_data),
    .key_fg   (s2_fg),
    .key_mac  (s2_da),
    .hit      (st_hit),
    .ports    (st_ports),
    .override (st_override)
  );

  vlan_table #(.DEPTH(lookup_pkg::VLAN_DEPTH)) u_vlan (
    .clk      (REF_CLK),
    .rst      (RST),
    .wr_en    (vt_wr_en),
    .wr_addr  (next_cmd_idx),
    .wr_data  (ind_data[lookup_pkg::VLAN_W-1:0]),
    .rd_addr  (cmd_idx),
    .rd_data  (vt_rd_data),
    .key_vid  (s1_vid),
    .hit      (vt_hit),
    .memb     (vt_memb),
    .fg       (vt_fg)
  );

endmodule // switch_address_vlan_lookup

// >>> src/lookup_pkg.sv
// Constants shared by the forwarding look-up engine and its two tables.
// Assumes registers are reached by word index; the byte address is four times the index.
package lookup_pkg;

  localparam int NUM_PORTS    = 5;
  localparam int MAC_W        = 48;
  localparam int VID_W        = 12;
  localparam int FG_W         = 4;
  localparam int STATIC_DEPTH = 8;
  localparam int VLAN_DEPTH   = 16;
  localparam int STATIC_W     = 60;
  localparam int VLAN_W       = 22;
  localparam int IND_W        = 72;
  localparam int IND_USED_W   = 69;

  // Register indices.
  localparam logic [6:0] IDX_GLOBAL_CTRL5  = 7'h05;
  localparam logic [6:0] IDX_PORT_VID_BASE = 7'h20;
  localparam logic [6:0] IDX_IND_CTRL      = 7'h6e;
  localparam logic [6:0] IDX_IND_ADDR      = 7'h6f;
  localparam logic [6:0] IDX_IND_DATA_TOP  = 7'h70;
  localparam logic [6:0] IDX_IND_DATA_LOW  = 7'h78;

  // Control fields.
  localparam int         VLAN_MODE_BIT = 7;
  localparam int         CTRL_READ_BIT = 4;
  localparam int         CTRL_TBL_LSB  = 2;
  localparam logic [1:0] TBL_STATIC    = 2'h0;
  localparam logic [1:0] TBL_VLAN      = 2'h1;

  // Static entry fields, write layout, which is also the stored layout.
  localparam int SW_FG_LSB   = 56;
  localparam int SW_USE_FG   = 55;
  localparam int S_OVERRIDE  = 54;
  localparam int S_VALID     = 53;
  localparam int S_PORTS_LSB = 48;

  // VLAN entry fields.
  localparam int V_VALID    = 21;
  localparam int V_MEMB_LSB = 16;
  localparam int V_FG_LSB   = 12;

  // Reset values.
  localparam logic [21:0] VLAN_ENTRY_RESET = 22'h3f0001;
  localparam logic [11:0] PORT_VID_RESET   = 12'h001;
  localparam logic [7:0]  REG_RESET        = 8'h00;
  localparam logic [4:0]  ALL_PORTS        = 5'h1f;

endpackage

// >>> src/vlan_table.sv
// VLAN table: register-backed entries, one write port, a registered read port
// and a registered search by VLAN ID. Assumes a single clock and async reset.
`timescale 1ns/10ps
module vlan_table #(
  parameter int DEPTH = lookup_pkg::VLAN_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic                         clk,     // Core clock.
  input  wire logic                         rst,     // Async reset, high.
  input  wire logic                         wr_en,   // Whole-entry write.
  input  wire logic [AW-1:0]                wr_addr, // Entry written.
  input  wire logic [lookup_pkg::VLAN_W-1:0] wr_data, // Entry value.
  input  wire logic [AW-1:0]                rd_addr, // Entry read.
  output logic      [lookup_pkg::VLAN_W-1:0] rd_data, // Registered entry.
  input  wire logic [lookup_pkg::VID_W-1:0] key_vid, // VLAN ID searched.
  output logic                              hit,     // Valid entry matched.
  output logic      [lookup_pkg::NUM_PORTS-1:0] memb, // Member ports.
  output logic      [lookup_pkg::FG_W-1:0]  fg       // Filter group.
);

  logic [lookup_pkg::VLAN_W-1:0]    mem      [DEPTH];
  logic [lookup_pkg::VLAN_W-1:0]    next_mem [DEPTH];
  logic [lookup_pkg::VLAN_W-1:0]    next_rd_data;
  logic                             next_hit;
  logic [lookup_pkg::NUM_PORTS-1:0] next_memb;
  logic [lookup_pkg::FG_W-1:0]      next_fg;

  always_comb begin
    next_mem = mem;
    if (wr_en) begin
      next_mem[wr_addr] = wr_data;
    end
    next_rd_data = mem[rd_addr];
    next_hit     = 1'b0;
    next_memb    = '0;
    next_fg      = '0;
    // Scanning downward lets the lowest matching entry win.
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (mem[i][lookup_pkg::V_VALID] && mem[i][lookup_pkg::VID_W-1:0] == key_vid) begin
        next_hit  = 1'b1;
        next_memb = mem[i][lookup_pkg::V_MEMB_LSB +: lookup_pkg::NUM_PORTS];
        next_fg   = mem[i][lookup_pkg::V_FG_LSB +: lookup_pkg::FG_W];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= lookup_pkg::VLAN_ENTRY_RESET;
      end
      rd_data <= '0;
      hit     <= 1'b0;
      memb    <= '0;
      fg      <= '0;
    end else begin
      mem     <= next_mem;
      rd_data <= next_rd_data;
      hit     <= next_hit;
      memb    <= next_memb;
      fg      <= next_fg;
    end
  end

endmodule // vlan_table

// >>> src/static_mac_table.sv
// Static MAC table: entries held in write layout, a registered read port and a
// registered parallel match. Nothing but the write port ever changes an entry.
`timescale 1ns/10ps
module static_mac_table #(
  parameter int DEPTH = lookup_pkg::STATIC_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic                           clk,      // Core clock.
  input  wire logic                           rst,      // Async reset, high.
  input  wire logic                           wr_en,    // Whole-entry write.
  input  wire logic [AW-1:0]                  wr_addr,  // Entry written.
  input  wire logic [lookup_pkg::STATIC_W-1:0] wr_data, // Entry value.
  input  wire logic [AW-1:0]                  rd_addr,  // Entry read.
  output logic      [lookup_pkg::STATIC_W-1:0] rd_data, // Registered entry.
  input  wire logic [lookup_pkg::FG_W-1:0]    key_fg,   // Filter group key.
  input  wire logic [lookup_pkg::MAC_W-1:0]   key_mac,  // Destination key.
  output logic                                hit,      // Valid entry matched.
  output logic      [lookup_pkg::NUM_PORTS-1:0] ports,  // Forwarding ports.
  output logic                                override  // Spanning-tree bypass.
);

  logic [lookup_pkg::STATIC_W-1:0]  mem      [DEPTH];
  logic [lookup_pkg::STATIC_W-1:0]  next_mem [DEPTH];
  logic [lookup_pkg::STATIC_W-1:0]  next_rd_data;
  logic                             next_hit;
  logic [lookup_pkg::NUM_PORTS-1:0] next_ports;
  logic                             next_override;

  always_comb begin
    next_mem = mem;
    if (wr_en) begin
      next_mem[wr_addr] = wr_data;
    end
    next_rd_data  = mem[rd_addr];
    next_hit      = 1'b0;
    next_ports    = '0;
    next_override = 1'b0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (mem[i][lookup_pkg::S_VALID]
          && mem[i][lookup_pkg::MAC_W-1:0] == key_mac
          && (!mem[i][lookup_pkg::SW_USE_FG]
              || mem[i][lookup_pkg::SW_FG_LSB +: lookup_pkg::FG_W] == key_fg)) begin
        next_hit      = 1'b1;
        next_ports    = mem[i][lookup_pkg::S_PORTS_LSB +: lookup_pkg::NUM_PORTS];
        next_override = mem[i][lookup_pkg::S_OVERRIDE];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      rd_data  <= '0;
      hit      <= 1'b0;
      ports    <= '0;
      override <= 1'b0;
    end else begin
      mem      <= next_mem;
      rd_data  <= next_rd_data;
      hit      <= next_hit;
      ports    <= next_ports;
      override <= next_override;
    end
  end

endmodule // static_mac_table

// >>> dv/dyn_table_model.sv
// Dynamic address table model that knows one address and answers only while a query is up.
// Assumes that the engine samples the answer in the query cycle.
`timescale 1ns/10ps
module dyn_table_model #(
  parameter logic [47:0] KNOWN = 48'h0
) (
  input  wire logic        q,  // Query.
  input  wire logic [47:0] da, // Destination key.
  input  wire logic [47:0] sa, // Source key.
  output logic             dh, // Destination hit.
  output logic             sh, // Source hit.
  output logic       [4:0] dp  // Ports.
);
  // Outside a query the hit lines are inverted and the ports read 0e, so that a stale answer never looks valid.
  assign dh = (da == KNOWN) ^ !q;
  assign sh = (sa == KNOWN) ^ !q;
  assign dp = q ? 5'h1f : 5'h0e;
endmodule // dyn_table_model

// >>> dv/switch_address_vlan_lookup_checker.sv
// Checker for the timing and decision relations at the look-up engine's ports.
// Assumes the latencies that the designer gave for the bus and the look-up pipe.
`timescale 1ns/10ps
module switch_address_vlan_lookup_checker (
  input wire logic REF_CLK, RST, WB_ACK_O, LKP_REQ, DYN_QUERY, DYN_SA_HIT, RES_VALID,
  input wire logic RES_DROP, RES_LEARN, RES_OVERRIDE,
  input wire logic [31:0] WB_DAT_O,
  input wire logic [3:0] DYN_FG, RES_FG,
  input wire logic [4:0] RES_PORTS
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
  a_data_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 0) else $error("data");
  a_query_lat: assert property (LKP_REQ |-> ##3 DYN_QUERY) else $error("query");
  a_result_lat: assert property (LKP_REQ |-> ##4 RES_VALID) else $error("result");
  a_drop_quiet: assert property (RES_VALID && RES_DROP |-> !RES_LEARN && RES_PORTS == 0)
    else $error("drop");
  a_learn_sa: assert property (RES_VALID && !RES_DROP |-> RES_LEARN == !$past(DYN_SA_HIT))
    else $error("learn");
  a_idle_zero: assert property (!RES_VALID |-> RES_PORTS == 0 && !RES_LEARN && !RES_OVERRIDE)
    else $error("idle");
  a_group_used: assert property (DYN_QUERY |=> RES_VALID && RES_FG == $past(DYN_FG))
    else $error("group");
endmodule // switch_address_vlan_lookup_checker
bind switch_address_vlan_lookup switch_address_vlan_lookup_checker i_chk (.REF_CLK, .RST,
  .WB_ACK_O, .LKP_REQ, .DYN_QUERY, .DYN_SA_HIT, .RES_VALID, .RES_DROP, .RES_LEARN,
  .RES_OVERRIDE, .WB_DAT_O, .DYN_FG, .RES_FG, .RES_PORTS);

// >>> dv/switch_address_vlan_lookup_bench.sv
// Bench that drives table commands over Wishbone and runs look-ups against the table model.
// Assumes the latencies that the designer gave; SEL is tied to all bytes.
`timescale 1ns/10ps
module switch_address_vlan_lookup_bench;
  localparam logic [47:0] M = 48'h0a0b0c0d0e0f, U = 48'h111111111111;
  logic clk = 0, rst = 1, cyc = 0, we = 0, req = 0, tg = 0, ack, q, dh, sh, rv, rdp, rl, ro;
  logic [8:0] adr = 0;
  logic [31:0] dw = 0, dr, rd;
  logic [47:0] da = 0, sa = 0, qd, qs;
  logic [11:0] tv = 0, vid;
  logic [4:0] dp, rp;
  logic [3:0] fg, rf;
  logic [2:0] pt = 0;
  int errors = 0, compares = 0;
  switch_address_vlan_lookup i_dut (.REF_CLK(clk), .RST(rst), .WB_ADR_I(adr), .WB_DAT_I(dw),
    .WB_SEL_I(4'hf), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_DAT_O(dr), .WB_ACK_O(ack),
    .LKP_REQ(req), .LKP_DA(da), .LKP_SA(sa), .LKP_TAGGED(tg), .LKP_TAG_VID(tv), .LKP_PORT(pt),
    .DYN_QUERY(q), .DYN_FG(fg), .DYN_DA(qd), .DYN_SA(qs), .DYN_DA_HIT(dh), .DYN_DA_PORTS(dp),
    .DYN_SA_HIT(sh), .RES_VALID(rv), .RES_PORTS(rp), .RES_DROP(rdp), .RES_OVERRIDE(ro),
    .RES_LEARN(rl), .RES_FG(rf), .RES_VID(vid));
  dyn_table_model #(.KNOWN(M)) i_dyn (.q(q), .da(qd), .sa(qs), .dh(dh), .sh(sh), .dp(dp));
  initial forever #5 clk = ~clk;
  task automatic chk(string n, logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop;
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // The request is held up to the edge at which ack is sampled high; read data is taken there.
  task automatic wb(logic w, logic [6:0] i, logic [7:0] d);
    @(posedge clk);
    {cyc, we, adr, dw} <= {1'b1, w, i, 2'b00, 24'h0, d};
    do @(posedge clk); while (!ack);
    rd = dr;
    cyc <= 0;
  endtask
  task automatic lk(logic [47:0] d, s, logic t, logic [11:0] v, logic [2:0] p, logic [4:0] ep,
                    logic edp, eln, eov, logic [11:0] ev, logic [3:0] ef);
    int n = 0;
    @(posedge clk);
    {req, da, sa, tg, tv, pt} <= {1'b1, d, s, t, v, p};
    @(posedge clk);
    req <= 0;
    do @(negedge clk); while (!rv && ++n < 9);
    chk("valid", rv, 1'b1);
    chk("fg", rf, ef);
    chk("ports", rp, ep);
    chk("drop", rdp, edp);
    chk("learn", rl, eln);
    chk("override", ro, eov);
    chk("vid", vid, ev);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    wb(1, 7'h6e, 8'h14);
    wb(1, 7'h6f, 8'h02);
    wb(0, 7'h76, 0);
    chk("vlan_hi", rd, 32'h3f);
    wb(0, 7'h78, 0);
    chk("vlan_lo", rd, 32'h01);
    wb(0, 7'h10, 0);
    chk("unmapped", rd, 32'h0);
    for (int i = 0; i < 8; i++) wb(1, 7'h71 + 7'(i), 8'({8'h03, 8'h64, M} >> (56 - 8 * i)));
    wb(1, 7'h6e, 8'h00);
    wb(1, 7'h6f, 8'h07);
    wb(1, 7'h6e, 8'h10);
    wb(1, 7'h6f, 8'h07);
    wb(0, 7'h71, 0);
    chk("read_top", rd, 32'h06);
    wb(0, 7'h72, 0);
    chk("read_flags", rd, 32'h64);
    lk(M, U, 0, 0, 1, 5'h04, 0, 1, 1, 1, 0);
    lk(U, M, 0, 0, 1, 5'h1d, 0, 0, 0, 1, 0);
    wb(1, 7'h05, 8'h80);
    lk(U, M, 1, 12'h005, 1, 5'h00, 1, 0, 0, 12'h005, 0);
    lk(U, U, 1, 12'h000, 3, 5'h17, 0, 1, 0, 12'h001, 0);
    wb(1, 7'h72, 8'h44);
    wb(1, 7'h6e, 8'h00);
    wb(1, 7'h6f, 8'h07);
    lk(M, M, 0, 0, 2, 5'h1b, 0, 0, 0, 1, 0);
    wb(1, 7'h76, 8'h2b);
    wb(1, 7'h77, 8'h30);
    wb(1, 7'h78, 8'h05);
    wb(1, 7'h6e, 8'h04);
    wb(1, 7'h6f, 8'h00);
    lk(U, U, 1, 12'h005, 0, 5'h0a, 0, 1, 0, 12'h005, 4'h3);
    report_and_stop;
  end
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    report_and_stop;
  end
endmodule // switch_address_vlan_lookup_bench
